// file: pkg/pidl_consts.vh
// constants for the page register, memory identity and logic array block
`ifndef PIDL_CONSTS_VH
`define PIDL_CONSTS_VH

// ****************************************
// register offsets inside the register space window
// ****************************************
`define PIDL_PAGE_OFF      8'hE0
`define PIDL_ID0_OFF       8'hF0
`define PIDL_ID1_OFF       8'hF1

// ****************************************
// reset values and field positions
// ****************************************
`define PIDL_PAGE_RST      8'h00
`define PIDL_ID0_FL_LSB    0
`define PIDL_ID0_SR_LSB    4
`define PIDL_ID1_BS_LSB    0
`define PIDL_ID1_BT_LSB    4
`define PIDL_PMR0_FAST_BIT 3

// ****************************************
// array input bus and product term layout
// ****************************************
`define PIDL_BUS_W         66
`define PIDL_MAIN_SECT     8
`define PIDL_BOOT_SECT     4
`define PIDL_SEL_PT        3
`define PIDL_BOOT_PT_BASE  24
`define PIDL_SRAM_PT_BASE  36
`define PIDL_REGS_PT       39
`define PIDL_HALF_PT_BASE  40
`define PIDL_DEC_PT        43
`define PIDL_GEN_PT        100
`define PIDL_ALL_PT        143
`define PIDL_GEN_OUT       24
`define PIDL_PA_LO_PT      3
`define PIDL_PA_HI_PT      9
`define PIDL_PB_LO_PT      4
`define PIDL_PB_HI_PT      7
`define PIDL_PC_PT         1

// ****************************************
// standby timing
// ****************************************
`define PIDL_CLK_NS        5
`define PIDL_STBY_NS       70
`define PIDL_STBY_CYC      8'h0E

`endif

// file: rtl/pidl_top.v
// page register, memory identity registers and decode / general logic arrays
//
// Contract
// - eight-bit page register, written and read back by the microcontroller.
// - page register answers at offset E0h inside the register space window.
// - all page bits feed the arrays for flash and SRAM select equations.
// - spare page bits remain usable as general array inputs.
// - two read-only identity registers; writes leave them unchanged.
// - first identity register holds flash size low nibble, SRAM size high.
// - second identity register holds boot size low nibble, boot type bits 5:4.
// - second identity register bits 7 and 6 read zero.
// - two arrays: decode for internal selects, general for pins.
// - general array drives 24 port pins; a pin may be input instead.
// - product terms see 66 inputs in true and complemented form.
// - input bus: address, control, reset, power-down, ports, page, ready.
// - burst multiplexed mode feeds address bits 19:4 instead of 15:0.
// - with fast mode off, arrays stand by after inputs idle 70 ns.
// - fast mode is bit 3 of power management register 0.
// - five power management register 2 bits block control signals.
// - decode array gives 8 main, 4 boot sector, SRAM, register selects.
// - decode array gives flash half select from three product terms.
// - decode equations take address, page and port inputs as terms.
// - general outputs own 3/9/4/7/1 native product terms per pin group.
// - general outputs may borrow unused product terms of other pins.
`timescale 1ns/1ps
`include "pidl_consts.vh"

// ****************************************
// one product term of the shared and array
// ****************************************
module pidl_pterm (
  // term programming
  input  wire [`PIDL_BUS_W-1:0] true_mask_i,
  input  wire [`PIDL_BUS_W-1:0] comp_mask_i,
  input  wire                   enable_i,
  // array input bus
  input  wire [`PIDL_BUS_W-1:0] bus_i,
  // term result
  output wire                   hit_o
);

  // an unprogrammed term stays low because its enable is clear; an enabled term with empty masks always hits
  assign hit_o = enable_i & ~|(true_mask_i & ~bus_i) & ~|(comp_mask_i & bus_i);

endmodule

// ****************************************
// top of the block
// ****************************************
module pidl_top #(
  parameter [3:0] FLASH_SIZE_CODE = 4'h0,
  parameter [3:0] SRAM_SIZE_CODE  = 4'h0,
  parameter [3:0] BOOT_SIZE_CODE  = 4'h0,
  parameter [1:0] BOOT_TYPE_CODE  = 2'h0,
  parameter [7:0] STBY_CYCLES     = `PIDL_STBY_CYC
) (
  // clock, reset, enable
  input  wire                   clk_i,
  input  wire                   resetn_i,
  input  wire                   ce_i,
  // microcontroller bus
  input  wire [19:0]            addr_i,
  input  wire [2:0]             cntl_i,
  input  wire                   burst_mux_mode_i,
  input  wire                   reg_wr_i,
  input  wire                   reg_rd_i,
  input  wire [7:0]             reg_wdata_i,
  // other array inputs
  input  wire                   array_reset_i,
  input  wire                   power_down_input_i,
  input  wire [7:0]             port_a_i,
  input  wire [7:0]             port_b_i,
  input  wire [7:0]             port_c_i,
  input  wire [3:0]             port_d_i,
  input  wire [7:0]             port_f_i,
  input  wire                   flash_ready_i,
  // power management settings
  input  wire [7:0]             power_mgmt_reg0_i,
  input  wire [7:0]             power_mgmt_reg2_i,
  // product term programming
  input  wire                   cfg_we_i,
  input  wire [7:0]             cfg_index_i,
  input  wire [`PIDL_BUS_W-1:0] cfg_true_i,
  input  wire [`PIDL_BUS_W-1:0] cfg_comp_i,
  input  wire                   cfg_enable_i,
  input  wire [4:0]             cfg_owner_i,
  input  wire [23:0]            pin_is_output_i,
  // decode array selects
  output reg  [7:0]             main_sector_sel_o,
  output reg  [3:0]             boot_sector_sel_o,
  output reg                    sram_sel_o,
  output reg                    register_space_select_o,
  output reg                    flash_half_select_o,
  // general array pins
  output reg  [23:0]            general_logic_array_o,
  output reg  [23:0]            general_pin_drive_o,
  // register read data and state
  output reg  [7:0]             page_bits_o,
  output reg  [7:0]             reg_rdata_o,
  output reg                    reg_rdata_valid_o,
  output reg                    standby_o
);

  // separate loop indices, so no variable is written by two processes
  integer k;
  integer m;

  // native owner pin of a general term, by position in the general term list
  function [4:0] pidl_native_owner;
    input integer idx;
    integer a;
    integer b;
    integer c;
    integer d;
    integer r;
    begin
      a = 4 * `PIDL_PA_LO_PT;
      b = a + 4 * `PIDL_PA_HI_PT;
      c = b + 4 * `PIDL_PB_LO_PT;
      d = c + 4 * `PIDL_PB_HI_PT;
      if (idx < a) begin
        r = idx / `PIDL_PA_LO_PT;
      end else if (idx < b) begin
        r = 4 + (idx - a) / `PIDL_PA_HI_PT;
      end else if (idx < c) begin
        r = 8 + (idx - b) / `PIDL_PB_LO_PT;
      end else if (idx < d) begin
        r = 12 + (idx - c) / `PIDL_PB_HI_PT;
      end else begin
        r = 16 + (idx - d) / `PIDL_PC_PT;
      end
      // owner numbers stay below 24, so the low five bits carry them whole
      pidl_native_owner = r[4:0];
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg  [`PIDL_BUS_W-1:0] pt_true [0:`PIDL_ALL_PT-1];
  reg  [`PIDL_BUS_W-1:0] pt_comp [0:`PIDL_ALL_PT-1];
  reg  [`PIDL_ALL_PT-1:0] pt_en;
  reg  [4:0]             pt_owner [0:`PIDL_GEN_PT-1];
  reg  [`PIDL_BUS_W-1:0] bus_seen;
  reg  [7:0]             idle_cnt;

  wire [15:0]            arr_addr;
  wire [2:0]             arr_cntl;
  wire                   arr_rst;
  wire                   arr_pdn;
  wire [`PIDL_BUS_W-1:0] arr_bus;
  wire [`PIDL_ALL_PT-1:0] pt_hit;
  wire [7:0]             main_or;
  wire [3:0]             boot_or;
  wire                   fast_mode;
  wire                   bus_moved;
  wire                   regs_hit;
  wire [7:0]             id0_value;
  wire [7:0]             id1_value;
  reg  [23:0]            gen_or;
  reg  [7:0]             next_rdata;
  reg  [7:0]             next_idle;
  reg                    next_standby;

  // ****************************************
  // array input bus
  // ****************************************
  // burst mode keeps the low nibble off the bus since it changes within a burst
  assign arr_addr = burst_mux_mode_i ? addr_i[19:4] : addr_i[15:0];
  // blocking a used control signal would break its equations; software owns that
  assign arr_cntl = cntl_i & ~power_mgmt_reg2_i[2:0];
  assign arr_rst  = array_reset_i & ~power_mgmt_reg2_i[3];
  assign arr_pdn  = power_down_input_i & ~power_mgmt_reg2_i[4];
  // bit order, lsb first: address, control, reset, power-down, ports a b c d f,
  // then the page bits and the ready flag at the top
  // page bits join the bus whole, so spare ones serve general logic too
  assign arr_bus  = {flash_ready_i, page_bits_o, port_f_i, port_d_i, port_c_i,
                     port_b_i, port_a_i, arr_pdn, arr_rst, arr_cntl, arr_addr};

  // ****************************************
  // product terms
  // ****************************************
  // one term per programmed slot, decode and general share the bus
  genvar g;
  generate
    for (g = 0; g < `PIDL_ALL_PT; g = g + 1) begin : gen_pt
      pidl_pterm u_pt (
        .true_mask_i (pt_true[g]),
        .comp_mask_i (pt_comp[g]),
        .enable_i    (pt_en[g]),
        .bus_i       (arr_bus),
        .hit_o       (pt_hit[g])
      );
    end
    // sector selects, three terms each, any bus input may appear in them
    for (g = 0; g < `PIDL_MAIN_SECT; g = g + 1) begin : gen_main
      assign main_or[g] = |pt_hit[g*`PIDL_SEL_PT +: `PIDL_SEL_PT];
    end
    for (g = 0; g < `PIDL_BOOT_SECT; g = g + 1) begin : gen_boot
      assign boot_or[g] = |pt_hit[`PIDL_BOOT_PT_BASE + g*`PIDL_SEL_PT +: `PIDL_SEL_PT];
    end
  endgenerate

  // register space select is a single term and gates all register access
  assign regs_hit = pt_hit[`PIDL_REGS_PT];

  // general outputs: every term ORs into the pin that currently owns it
  always @* begin
    gen_or = 24'h000000;
    for (k = 0; k < `PIDL_GEN_PT; k = k + 1) begin
      if (pt_hit[`PIDL_DEC_PT + k]) begin
        gen_or[pt_owner[k]] = 1'b1;
      end
    end
  end

  // ****************************************
  // programming store
  // ****************************************
  // owners start at the native split; a write may hand a term to any pin
  // an index past the last term is dropped rather than wrapped onto a live term
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pt_en <= {`PIDL_ALL_PT{1'b0}};
      for (m = 0; m < `PIDL_ALL_PT; m = m + 1) begin
        pt_true[m] <= {`PIDL_BUS_W{1'b0}};
        pt_comp[m] <= {`PIDL_BUS_W{1'b0}};
      end
      for (m = 0; m < `PIDL_GEN_PT; m = m + 1) begin
        pt_owner[m] <= pidl_native_owner(m);
      end
    end else if (ce_i && cfg_we_i && cfg_index_i < `PIDL_ALL_PT) begin
      pt_true[cfg_index_i] <= cfg_true_i;
      pt_comp[cfg_index_i] <= cfg_comp_i;
      pt_en[cfg_index_i]   <= cfg_enable_i;
      if (cfg_index_i >= `PIDL_DEC_PT && cfg_owner_i < `PIDL_GEN_OUT) begin
        pt_owner[cfg_index_i - `PIDL_DEC_PT] <= cfg_owner_i;
      end
    end
  end

  // ****************************************
  // registers in the register space
  // ****************************************
  // identity values are wired constants, nothing can overwrite them
  assign id0_value = {SRAM_SIZE_CODE, FLASH_SIZE_CODE};
  assign id1_value = {2'b00, BOOT_TYPE_CODE, BOOT_SIZE_CODE};

  // read mux; unmapped offsets read zero
  always @* begin
    case (addr_i[7:0])
      `PIDL_PAGE_OFF: next_rdata = page_bits_o;
      `PIDL_ID0_OFF:  next_rdata = id0_value;
      `PIDL_ID1_OFF:  next_rdata = id1_value;
      default:        next_rdata = 8'h00;
    endcase
  end

  // page register, the only writable register of the block
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      page_bits_o <= `PIDL_PAGE_RST;
    end else if (ce_i && reg_wr_i && regs_hit && addr_i[7:0] == `PIDL_PAGE_OFF) begin
      page_bits_o <= reg_wdata_i;
    end
  end

  // read data registered one cycle after the strobe
  // the valid pulse lets the bus side tell a refused read from a read of zero
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o       <= 8'h00;
      reg_rdata_valid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rdata_valid_o <= reg_rd_i & regs_hit;
      if (reg_rd_i && regs_hit) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // ****************************************
  // automatic standby
  // ****************************************
  assign fast_mode = power_mgmt_reg0_i[`PIDL_PMR0_FAST_BIT];
  assign bus_moved = arr_bus != bus_seen;

  // limitation: idleness is judged per clock edge, so a glitch that comes and
  // goes between two edges does not wake the arrays
  // any bus change wakes the arrays; fast mode keeps them awake for speed
  always @* begin
    next_idle    = idle_cnt;
    next_standby = 1'b0;
    if (bus_moved || fast_mode) begin
      next_idle = 8'h00;
    end else if (idle_cnt < STBY_CYCLES) begin
      next_idle = idle_cnt + 8'h01;
    end
    if (!fast_mode && !bus_moved && next_idle >= STBY_CYCLES) begin
      next_standby = 1'b1;
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_seen  <= {`PIDL_BUS_W{1'b0}};
      idle_cnt  <= 8'h00;
      standby_o <= 1'b0;
    end else if (ce_i) begin
      bus_seen  <= arr_bus;
      idle_cnt  <= next_idle;
      standby_o <= next_standby;
    end
  end

  // ****************************************
  // array outputs
  // ****************************************
  // in standby the outputs hold; inputs are still, so the held values are right
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      main_sector_sel_o       <= 8'h00;
      boot_sector_sel_o       <= 4'h0;
      sram_sel_o              <= 1'b0;
      register_space_select_o <= 1'b0;
      flash_half_select_o     <= 1'b0;
      general_logic_array_o   <= 24'h000000;
      general_pin_drive_o     <= 24'h000000;
    end else if (ce_i && !standby_o) begin
      main_sector_sel_o       <= main_or;
      boot_sector_sel_o       <= boot_or;
      sram_sel_o              <= |pt_hit[`PIDL_SRAM_PT_BASE +: `PIDL_SEL_PT];
      register_space_select_o <= regs_hit;
      flash_half_select_o     <= |pt_hit[`PIDL_HALF_PT_BASE +: `PIDL_SEL_PT];
      // a pin not taken as output is left to the port logic as an input
      general_logic_array_o   <= gen_or & pin_is_output_i;
      general_pin_drive_o     <= pin_is_output_i;
    end
  end

endmodule

// file: tb/pidl_chk_asserts.sv
// assertion checker for the page, identity and pin outputs of pidl_top
`timescale 1ns/1ps
// ********
// checker
// ********
module pidl_chk #(
  parameter [3:0] FLASH_SIZE_CODE = 4'h0,
  parameter [3:0] SRAM_SIZE_CODE  = 4'h0,
  parameter [3:0] BOOT_SIZE_CODE  = 4'h0,
  parameter [1:0] BOOT_TYPE_CODE  = 2'h0
) (
  // clock, reset and bus inputs
  input wire        clk_i,
  input wire        resetn_i,
  input wire        ce_i,
  input wire [19:0] addr_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [7:0]  reg_wdata_i,
  input wire [7:0]  power_mgmt_reg0_i,
  // outputs watched
  input wire [7:0]  page_bits_o,
  input wire [7:0]  reg_rdata_o,
  input wire        reg_rdata_valid_o,
  input wire        standby_o,
  input wire [7:0]  main_sector_sel_o,
  input wire [23:0] general_logic_array_o,
  input wire [23:0] general_pin_drive_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // a read at one offset that the block answered on the next edge
  sequence s_read(a);
    ce_i && reg_rd_i && addr_i[7:0] == a ##1 reg_rdata_valid_o;
  endsequence
  chk_reset_page: assert property ($rose(resetn_i) |-> page_bits_o == 8'h00)
    else $error("page not clear after reset");
  chk_page_keep: assert property (!(ce_i && reg_wr_i) |=> $stable(page_bits_o))
    else $error("page changed without a write");
  // the past reset term keeps a mid-run reset from looking like a load
  chk_page_load: assert property ($changed(page_bits_o) && $past(resetn_i)
    |-> $past(addr_i[7:0]) == 8'hE0 && $past(reg_wdata_i) == page_bits_o)
    else $error("page loaded without a write at its offset");
  chk_page_read: assert property (s_read(8'hE0) |-> reg_rdata_o == $past(page_bits_o))
    else $error("page read back wrong");
  chk_id0_read: assert property (s_read(8'hF0)
    |-> reg_rdata_o == {SRAM_SIZE_CODE, FLASH_SIZE_CODE})
    else $error("first identity wrong");
  chk_id1_read: assert property (s_read(8'hF1)
    |-> reg_rdata_o[5:0] == {BOOT_TYPE_CODE, BOOT_SIZE_CODE})
    else $error("second identity wrong");
  chk_id1_spare: assert property (s_read(8'hF1) |-> reg_rdata_o[7:6] == 2'b00)
    else $error("spare identity bits set");
  chk_valid_cause: assert property (reg_rdata_valid_o && $past(ce_i) |-> $past(reg_rd_i))
    else $error("read answer without a read");
  chk_fast_wake: assert property (ce_i && power_mgmt_reg0_i[3] |=> !standby_o)
    else $error("standby while fast");
  chk_stby_hold: assert property (standby_o && ce_i |=> $stable(main_sector_sel_o))
    else $error("selects moved in standby");
  chk_pin_mask: assert property ((general_logic_array_o & ~general_pin_drive_o) == 24'h0)
    else $error("general output on an input pin");
endmodule

bind pidl_top pidl_chk #(
  .FLASH_SIZE_CODE(FLASH_SIZE_CODE),
  .SRAM_SIZE_CODE(SRAM_SIZE_CODE),
  .BOOT_SIZE_CODE(BOOT_SIZE_CODE),
  .BOOT_TYPE_CODE(BOOT_TYPE_CODE)
) u_chk (
  .clk_i, .resetn_i, .ce_i, .addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .power_mgmt_reg0_i, .page_bits_o, .reg_rdata_o, .reg_rdata_valid_o, .standby_o,
  .main_sector_sel_o, .general_logic_array_o, .general_pin_drive_o
);

// file: tb/pidl_mcu_model.sv
// microcontroller bus model that writes and reads the register space
`timescale 1ns/1ps
// ********
// bus model
// ********
module pidl_mcu_model (
  // clock and answer
  input  wire        clk_i,
  input  wire        valid_i,
  input  wire [7:0]  rdata_i,
  // request
  output reg  [19:0] addr_o,
  output reg         wr_o,
  output reg         rd_o,
  output reg  [7:0]  wdata_o
);
  // idle bus at time zero
  initial begin
    addr_o = 20'h00000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // one write, held for the edge that takes it
  task wr(input [19:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d; // stale data would hide a late capture
    end
  endtask
  // one read; the answer shows right after the taking edge
  task rd(input [19:0] a, output [7:0] d, output ok);
    begin
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1;
      ok = valid_i;
      d = valid_i ? rdata_i : 8'h00;
    end
  endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the page, identity and logic array block
`timescale 1ns/1ps
// ********
// bench top
// ********
module tb_top;
  reg         clk_i, resetn_i, burst, arst, power_down_input, rdy, cfg_we, ok, ce, cfg_en;
  reg  [2:0]  cntl;
  reg  [3:0]  pd;
  reg  [4:0]  cfg_own;
  reg  [7:0]  pa, pb, pc, pf, pm0, pm2, cfg_idx, p, d;
  reg  [23:0] pin_out;
  reg  [31:0] seed;
  reg  [65:0] cfg_t, cfg_c;
  wire        wr, rd, valid, ssel, hsel, stby, rsel;
  wire [3:0]  bsel;
  wire [7:0]  wdata, rdata, page, msel;
  wire [19:0] addr;
  wire [23:0] gen, drv;
  integer     errors, comparisons, cyc, i;
  // design with identity codes 35h / 12h and a short standby count
  pidl_top #(.FLASH_SIZE_CODE(4'h5), .SRAM_SIZE_CODE(4'h3), .BOOT_SIZE_CODE(4'h2),
    .BOOT_TYPE_CODE(2'h1), .STBY_CYCLES(8'h02)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .addr_i(addr), .cntl_i(cntl),
    .burst_mux_mode_i(burst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .array_reset_i(arst), .power_down_input_i(power_down_input), .port_a_i(pa), .port_b_i(pb),
    .port_c_i(pc), .port_d_i(pd), .port_f_i(pf), .flash_ready_i(rdy),
    .power_mgmt_reg0_i(pm0), .power_mgmt_reg2_i(pm2), .cfg_we_i(cfg_we),
    .cfg_index_i(cfg_idx), .cfg_true_i(cfg_t), .cfg_comp_i(cfg_c), .cfg_enable_i(cfg_en),
    .cfg_owner_i(cfg_own), .pin_is_output_i(pin_out), .main_sector_sel_o(msel),
    .boot_sector_sel_o(bsel), .sram_sel_o(ssel), .register_space_select_o(rsel),
    .flash_half_select_o(hsel), .general_logic_array_o(gen), .general_pin_drive_o(drv),
    .page_bits_o(page), .reg_rdata_o(rdata), .reg_rdata_valid_o(valid), .standby_o(stby));
  pidl_mcu_model u_mcu (.clk_i(clk_i), .valid_i(valid), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      end_of_test;
    end
  end
  function [7:0] exp_main(input [7:0] pg);
    exp_main = (pg < 8) ? (8'h01 << pg[2:0]) : 8'h00;
  endfunction
  // pin 0 follows page bit 7, pin 23 page bit 6 through a borrowed term
  function [23:0] exp_gen(input [7:0] pg, input [23:0] po);
    exp_gen = {pg[6], 22'h0, pg[7]} & po;
  endfunction
  task chk(input string n, input [23:0] e, input [23:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("wrong value %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task prog(input [7:0] n, input [65:0] t, input [65:0] c, input [4:0] o);
    begin
      @(posedge clk_i);
      cfg_we <= 1'b1;
      cfg_idx <= n;
      cfg_t <= t;
      cfg_c <= c;
      cfg_own <= o;
      @(posedge clk_i);
      cfg_we <= 1'b0;
    end
  endtask
  task end_of_test;
    begin
      if (errors == 0 && comparisons > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  // main sequence
  initial begin
    seed = $urandom(32'h45a38223);
    errors = 0;
    comparisons = 0;
    cyc = 0;
    {resetn_i, burst, arst, power_down_input, rdy, cfg_we, cntl, pd, pa, pb, pc, pf} = 0;
    {cfg_own, cfg_idx, cfg_t, cfg_c, pm2} = 0;
    pm0 = 8'h08;
    {ce, cfg_en} = 2'b11;
    pin_out = 24'h800001;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("page", 24'h0, {16'h0, page});
    // window needs address 80xxh; sectors need an exact page value
    prog(8'd39, 66'h8000, 66'h7F00, 5'd31);
    for (i = 0; i < 8; i = i + 1) begin
      prog(8'(i * 3), {1'b0, i[7:0], 57'h0}, {1'b0, ~i[7:0], 57'h0}, 5'd31);
    end
    for (i = 0; i < 4; i = i + 1) begin
      prog(8'(24 + i * 3), 66'h1 << (45 + i), 66'h0, 5'd31);
    end
    prog(8'd36, 66'h1 << 65, 66'h0, 5'd31);
    prog(8'd40, 66'h1 << 14, 66'h0, 5'd31);
    prog(8'd41, 66'h1 << 16, 66'h0, 5'd31);
    prog(8'd43, 66'h1 << 64, 66'h0, 5'd31);
    prog(8'd55, 66'h1 << 63, 66'h0, 5'd23);
    u_mcu.wr(20'h080E0, 8'h5A);
    u_mcu.rd(20'h080E0, d, ok);
    chk("page read", 24'h5A, {16'h0, d});
    u_mcu.wr(20'h080F0, 8'hFF);
    u_mcu.rd(20'h080F0, d, ok);
    chk("id0", 24'h35, {16'h0, d});
    u_mcu.rd(20'h080F1, d, ok);
    chk("id1", 24'h12, {16'h0, d});
    u_mcu.rd(20'h080E5, d, ok);
    chk("unmapped", 24'h0, {16'h0, d});
    u_mcu.wr(20'h000E0, 8'hC3);
    u_mcu.rd(20'h000E0, d, ok);
    chk("outside answer", 24'h0, {23'h0, ok});
    @(posedge clk_i);
    burst <= 1'b1;
    u_mcu.wr(20'h080E0, 8'h11);
    #1;
    chk("burst miss", 24'h5A, {16'h0, page});
    u_mcu.wr(20'h800E0, 8'h22);
    // clock enable low freezes the page against a matching write
    @(posedge clk_i);
    burst <= 1'b0;
    ce <= 1'b0;
    #1;
    chk("burst hit", 24'h22, {16'h0, page});
    u_mcu.wr(20'h080E0, 8'h77);
    #1;
    chk("frozen page", 24'h22, {16'h0, page});
    @(posedge clk_i);
    ce <= 1'b1;
    // sector pages 0 to 7 first, ninth pass a corner with both pins on, then random pages; array inputs are random on every pass
    for (i = 0; i < 28; i = i + 1) begin
      @(posedge clk_i);
      p = (i < 8) ? i[7:0] : ((i == 8) ? 8'hC0 : 8'($urandom));
      cntl <= 3'($urandom);
      pd <= 4'($urandom);
      {rdy, arst, power_down_input} <= 3'($urandom);
      pm2 <= 8'($urandom);
      pin_out <= (i == 8) ? 24'hFFFFFF : 24'($urandom);
      {pa, pb, pc, pf} <= $urandom;
      u_mcu.wr(20'h080E0, p);
      repeat (2) @(posedge clk_i);
      #1;
      chk("sector", {16'h0, exp_main(p)}, {16'h0, msel});
      chk("boot", {20'h0, pd}, {20'h0, bsel});
      chk("sram", {23'h0, rdy}, {23'h0, ssel});
      chk("half", {23'h0, cntl[0] & ~pm2[0]}, {23'h0, hsel});
      chk("general", exp_gen(p, pin_out), gen);
      chk("drive", pin_out, drv);
      chk("regs sel", 24'h1, {23'h0, rsel});
    end
    // a mid-run reset clears a known page
    u_mcu.wr(20'h080E0, 8'hA5);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk("page after reset", 24'h0, {16'h0, page});
    // a term written disabled never answers, though its masks match
    @(posedge clk_i);
    cfg_en <= 1'b0;
    prog(8'd39, 66'h8000, 66'h7F00, 5'd31);
    u_mcu.rd(20'h080E0, d, ok);
    chk("disabled term", 24'h0, {23'h0, ok});
    chk("regs sel off", 24'h0, {23'h0, rsel});
    @(posedge clk_i);
    pm0 <= 8'h00;
    repeat (8) @(posedge clk_i);
    #1;
    chk("standby", 24'h1, {23'h0, stby});
    @(posedge clk_i);
    pm0 <= 8'h08;
    repeat (2) @(posedge clk_i);
    #1;
    chk("awake", 24'h0, {23'h0, stby});
    end_of_test;
  end
endmodule
